// file: logic/mvi_pkg.sv
// constants for the multilevel vectored interrupt controller
// assumes: single clock domain, async active-high reset
`default_nettype none
package mvi_pkg;
	localparam int NUM_SRC = 16;
	localparam int NUM_VEC = 10;
	localparam int VEC_W   = 4;
	// priority levels: none < low < high < highest
	typedef enum logic [1:0] {
		MVI_LVL_NONE    = 2'h0,
		MVI_LVL_LOW     = 2'h1,
		MVI_LVL_HIGH    = 2'h2,
		MVI_LVL_HIGHEST = 2'h3
	} mvi_level_t;
	// vector addresses, index 0 is the smallest
	localparam logic [19:0] VEC_BASE = 20'h00003;
	localparam logic [19:0] VEC_STEP = 20'h00008;
	// source numbering
	localparam int SRC_PIN_A   = 0;
	localparam int SRC_PIN_B   = 1;
	localparam int SRC_PIN_C   = 2;
	localparam int SRC_T0L     = 3;
	localparam int SRC_PIN_E   = 4;
	localparam int SRC_PIN_D   = 5;
	localparam int SRC_PIN_F   = 6;
	localparam int SRC_T0H     = 7;
	localparam int SRC_SIO     = 8;
	localparam int SRC_T1L     = 9;
	localparam int SRC_T1H     = 10;
	localparam int SRC_PULSE_COUNTER_ONE_REQUEST    = 11;
	localparam int SRC_PULSE_COUNTER_TWO_REQUEST    = 12;
	localparam int SRC_ADC     = 13;
	localparam int SRC_PWMSTOP = 14;
	localparam int SRC_PWMCYC  = 15;
	// source to vector index map
	localparam logic [NUM_SRC*VEC_W-1:0] SRC_VEC = {
		4'h8, 4'h8, 4'h8, 4'h7, 4'h6, 4'h5, 4'h5, 4'h4,
		4'h4, 4'h3, 4'h3, 4'h2, 4'h2, 4'h2, 4'h1, 4'h0};
	localparam logic [2:0] FILT_LEN = 3'h4;
	// cycles after reset before pin events count: two sync flops, filter, history
	localparam logic [2:0] PIN_SETTLE = 3'h7;
endpackage : mvi_pkg
`default_nettype wire

// file: logic/mvi_filter.sv
// noise filter for the comparator edge path
// assumes: input already synchronised to mclk
`default_nettype none
module mvi_filter #(
	parameter logic [2:0] LEN = mvi_pkg::FILT_LEN
) (
	// clock and reset
	input  wire logic mclk,
	input  wire logic reset,
	// data
	input  wire logic din,
	output var  logic dout
);
	logic [2:0] cnt_r;
	// output follows input only after LEN stable cycles
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cnt_r <= 3'h0;
			dout  <= 1'b0;
		end else if (din == dout) begin
			cnt_r <= 3'h0;
		end else if (cnt_r == LEN - 3'h1) begin
			cnt_r <= 3'h0;
			dout  <= din;
		end else begin
			cnt_r <= cnt_r + 3'h1;
		end
	end
endmodule : mvi_filter
`default_nettype wire

// file: logic/mvi_ctrl.sv
// multilevel vectored interrupt priority controller
// assumes: pins asynchronous, peripheral requests are mclk pulses
`default_nettype none
// How it works
// - three levels low, high, highest ranked in that order
// - requests at or below the in-service level are refused
// - among pending vectors the highest level wins
// - equal level ties go to the smallest vector address
// - sixteen sources folded onto nine vectors
// - converter done, pwm stop and pwm cycle share vector 00043H
// - comparator edge shares pin c path with optional noise filter
// - any accepted request releases the core from halt
// - deep standby wakes on pin level; pins a, b only when level-set
module mvi_ctrl (
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        reset,
	// external pins (asynchronous)
	input  wire logic                        extIrqPinA,
	input  wire logic                        extIrqPinB,
	input  wire logic                        extIrqPinC,
	input  wire logic                        extIrqPinD,
	input  wire logic                        extIrqPinE,
	input  wire logic                        extIrqPinF,
	input  wire logic                        comparatorOutput,
	// pin configuration
	input  wire logic [5:0]                  pinLevelMode,
	input  wire logic [5:0]                  pinActiveHigh,
	input  wire logic                        cmpOnPinC,
	input  wire logic                        cmpFilterEn,
	// peripheral request pulses
	input  wire logic                        timer0LowHalfRequest,
	input  wire logic                        timer0HighHalfRequest,
	input  wire logic                        timer1LowHalfRequest,
	input  wire logic                        timer1HighHalfRequest,
	input  wire logic                        syncSerialRequest,
	input  wire logic                        pulseCounterOneRequest,
	input  wire logic                        pulseCounterTwoRequest,
	input  wire logic                        adcDoneRequest,
	input  wire logic                        fastPwmUnitStopRequest,
	input  wire logic                        fastPwmUnitCycleRequest,
	// software controls
	input  wire logic [15:0]                 srcEnable,
	input  wire logic [15:0]                 srcFlagClear,
	input  wire logic [9:0]                  vecHighSel,
	input  wire logic [1:0]                  vecHighestSel,
	// cpu handshake
	input  wire logic                        intAck,
	input  wire logic                        intReturn,
	input  wire logic                        haltMode,
	input  wire logic                        holdMode,
	// outputs
	output var  logic                        intReq,
	output var  logic [19:0]                 intVector,
	output var  mvi_pkg::mvi_level_t         intLevel,
	output var  logic [15:0]                 srcFlag,
	output var  mvi_pkg::mvi_level_t         svcLevel,
	output var  logic                        haltRelease,
	output var  logic                        holdWake
);
	// ==================================================
	// pin synchronisers
	logic [6:0] pinMeta_r;
	logic [6:0] pinSync_r;
	logic [6:0] pinPrev_r;
	logic [6:0] pinIn;
	logic [5:0] pinAct;
	logic [5:0] pinEvt;
	logic [2:0] settle_r;
	logic       pinsReady;
	// pin events wait until synchronisers, filter and history hold real samples,
	// so a pin already active at reset gives no false edge
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			settle_r <= 3'h0;
		end else if (settle_r != mvi_pkg::PIN_SETTLE) begin
			settle_r <= settle_r + 3'h1;
		end
	end
	assign pinsReady = (settle_r == mvi_pkg::PIN_SETTLE);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pinMeta_r <= 7'h0;
			pinSync_r <= 7'h0;
			pinPrev_r <= 7'h0;
		end else begin
			pinMeta_r <= {comparatorOutput, extIrqPinF, extIrqPinE, extIrqPinD,
				extIrqPinC, extIrqPinB, extIrqPinA};
			pinSync_r <= pinMeta_r;
			pinPrev_r <= pinIn;
		end
	end
	logic cmpFilt;
	mvi_filter #(.LEN(mvi_pkg::FILT_LEN)) uFilt (
		.mclk  (mclk),
		.reset (reset),
		.din   (pinSync_r[6]),
		.dout  (cmpFilt)
	);
	// ==================================================
	// pin event detection
	always_comb begin
		pinIn     = pinSync_r;
		// comparator path replaces pin c, filter selectable
		if (cmpOnPinC) begin
			pinIn[2] = cmpFilterEn ? cmpFilt : pinSync_r[6];
		end
		for (int i = 0; i < 6; i++) begin
			pinAct[i] = pinActiveHigh[i] ? pinIn[i] : ~pinIn[i];
			pinEvt[i] = pinsReady && (pinLevelMode[i] ? pinAct[i]
				: (pinActiveHigh[i] ? (pinIn[i] & ~pinPrev_r[i])
				: (~pinIn[i] & pinPrev_r[i])));
		end
	end
	logic [15:0] srcEvt;
	always_comb begin
		srcEvt = 16'h0;
		srcEvt[mvi_pkg::SRC_PIN_A]   = pinEvt[0];
		srcEvt[mvi_pkg::SRC_PIN_B]   = pinEvt[1];
		srcEvt[mvi_pkg::SRC_PIN_C]   = pinEvt[2];
		srcEvt[mvi_pkg::SRC_PIN_D]   = pinEvt[3];
		srcEvt[mvi_pkg::SRC_PIN_E]   = pinEvt[4];
		srcEvt[mvi_pkg::SRC_PIN_F]   = pinEvt[5];
		srcEvt[mvi_pkg::SRC_T0L]     = timer0LowHalfRequest;
		srcEvt[mvi_pkg::SRC_T0H]     = timer0HighHalfRequest;
		srcEvt[mvi_pkg::SRC_T1L]     = timer1LowHalfRequest;
		srcEvt[mvi_pkg::SRC_T1H]     = timer1HighHalfRequest;
		srcEvt[mvi_pkg::SRC_SIO]     = syncSerialRequest;
		srcEvt[mvi_pkg::SRC_PULSE_COUNTER_ONE_REQUEST]    = pulseCounterOneRequest;
		srcEvt[mvi_pkg::SRC_PULSE_COUNTER_TWO_REQUEST]    = pulseCounterTwoRequest;
		srcEvt[mvi_pkg::SRC_ADC]     = adcDoneRequest;
		srcEvt[mvi_pkg::SRC_PWMSTOP] = fastPwmUnitStopRequest;
		srcEvt[mvi_pkg::SRC_PWMCYC]  = fastPwmUnitCycleRequest;
	end
	// ==================================================
	// sticky flags, set wins over clear
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			srcFlag <= 16'h0;
		end else begin
			srcFlag <= (srcFlag & ~srcFlagClear) | srcEvt;
		end
	end
	// ==================================================
	// fold sources onto vectors and rank
	function automatic logic [3:0] srcVec(input int s);
		srcVec = mvi_pkg::SRC_VEC[s*mvi_pkg::VEC_W +: mvi_pkg::VEC_W];
	endfunction : srcVec
	function automatic mvi_pkg::mvi_level_t vecLevel(input int v, input logic [9:0] hi,
		input logic [1:0] hx);
		if (v < 2) begin
			vecLevel = hx[v] ? mvi_pkg::MVI_LVL_HIGHEST : mvi_pkg::MVI_LVL_LOW;
		end else begin
			vecLevel = hi[v] ? mvi_pkg::MVI_LVL_HIGH : mvi_pkg::MVI_LVL_LOW;
		end
	endfunction : vecLevel
	logic [9:0]          vecPend;
	mvi_pkg::mvi_level_t winLvl;
	logic [3:0]          winVec;
	always_comb begin
		vecPend = 10'h0;
		for (int s = 0; s < mvi_pkg::NUM_SRC; s++) begin
			if (srcFlag[s] && srcEnable[s]) begin
				vecPend[srcVec(s)] = 1'b1;
			end
		end
		winLvl = mvi_pkg::MVI_LVL_NONE;
		winVec = 4'h0;
		// strict compare keeps the smallest vector on a tie
		for (int v = 0; v < mvi_pkg::NUM_VEC; v++) begin
			if (vecPend[v] && vecLevel(v, vecHighSel, vecHighestSel) > winLvl) begin
				winLvl = vecLevel(v, vecHighSel, vecHighestSel);
				winVec = 4'(v);
			end
		end
	end
	// ==================================================
	// in-service level stack
	logic [3:0] svcStack_r;
	logic       accept;
	assign accept = (winLvl > svcLevel);
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			svcStack_r <= 4'h0;
			svcLevel   <= mvi_pkg::MVI_LVL_NONE;
		end else if (intAck && intReq) begin
			svcStack_r <= svcStack_r | (4'h1 << intLevel);
			svcLevel   <= intLevel;
		end else if (intReturn) begin
			svcStack_r <= svcStack_r & ~(4'h1 << svcLevel);
			svcLevel   <= (svcStack_r[2] && svcLevel == mvi_pkg::MVI_LVL_HIGHEST)
				? mvi_pkg::MVI_LVL_HIGH
				: ((svcStack_r[1] && svcLevel != mvi_pkg::MVI_LVL_LOW)
				? mvi_pkg::MVI_LVL_LOW : mvi_pkg::MVI_LVL_NONE);
		end
	end
	// ==================================================
	// cpu request and standby release
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			intReq      <= 1'b0;
			intVector   <= mvi_pkg::VEC_BASE;
			intLevel    <= mvi_pkg::MVI_LVL_NONE;
			haltRelease <= 1'b0;
			holdWake    <= 1'b0;
		end else begin
			intReq      <= accept && !(intAck && intReq);
			intVector   <= mvi_pkg::VEC_BASE + 20'(winVec) * mvi_pkg::VEC_STEP;
			intLevel    <= winLvl;
			haltRelease <= haltMode && accept;
			holdWake    <= holdMode && pinsReady
				&& (|(pinAct & {4'hf, pinLevelMode[1:0]}));
		end
	end
	// ==================================================
	// checks
	a_nest_block: assert property (@(posedge mclk) disable iff (reset)
		intReq |-> (intLevel > $past(svcLevel)))
		else $error("request at or below service level");
	a_level_win: assert property (@(posedge mclk) disable iff (reset)
		(vecPend[0] && vecHighestSel[0]) |=> (intLevel == mvi_pkg::MVI_LVL_HIGHEST))
		else $error("highest level did not win");
	a_tie_small: assert property (@(posedge mclk) disable iff (reset)
		(vecPend[2] && vecPend[1:0] == 2'h0 && vecHighSel == 10'h0 && vecHighestSel == 2'h0)
		|-> winVec == 4'h2)
		else $error("tie not to smallest vector");
	a_adc_vec: assert property (@(posedge mclk) disable iff (reset)
		(vecPend == 10'h100) |=> (intVector == 20'h00043))
		else $error("shared vector wrong");
	a_flag_sticky: assert property (@(posedge mclk) disable iff (reset)
		(srcFlag[0] && !srcFlagClear[0]) |=> srcFlag[0])
		else $error("flag dropped");
	a_enable_gate: assert property (@(posedge mclk) disable iff (reset)
		(!srcEnable[9] && !(srcFlag[10] && srcEnable[10])) |-> !vecPend[5])
		else $error("disabled source pending");
	a_halt_wake: assert property (@(posedge mclk) disable iff (reset)
		(haltMode && accept) |=> haltRelease)
		else $error("halt not released");
	a_hold_edge: assert property (@(posedge mclk) disable iff (reset)
		(holdWake && $past(pinLevelMode[1:0]) == 2'h0) |-> $past(|pinAct[5:2]))
		else $error("edge pin woke hold");
	a_lvl_rank: assert property (@(posedge mclk) disable iff (reset)
		intReq |-> intLevel != mvi_pkg::MVI_LVL_NONE)
		else $error("request without level");
	c_nest: cover property (@(posedge mclk) disable iff (reset)
		intAck && intReq && svcLevel != mvi_pkg::MVI_LVL_NONE);
	c_halt: cover property (@(posedge mclk) disable iff (reset) haltRelease);
	c_hold: cover property (@(posedge mclk) disable iff (reset) holdWake);
	c_tie: cover property (@(posedge mclk) disable iff (reset) $countones(vecPend) > 1);
endmodule : mvi_ctrl
`default_nettype wire

// file: verif/mvi_cpu_model.sv
// cpu core model: takes requests and ends service on command
// assumes: intReq from the controller, commands from the bench
`default_nettype none
module mvi_cpu_model (
	// clock and reset
	input  wire logic mclk,
	input  wire logic reset,
	// bench commands
	input  wire logic ackEn,
	input  wire logic retGo,
	// controller side
	input  wire logic intReq,
	output var  logic intAck,
	output var  logic intReturn
);
	timeunit 1ns;
	timeprecision 1ps;
	logic retGo_r;
	// one ack per request, only while it stands
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			intAck <= 1'b0;
			retGo_r <= 1'b0;
			intReturn <= 1'b0;
		end else begin
			intAck <= ackEn & intReq & ~intAck;
			retGo_r <= retGo;
			intReturn <= retGo & ~retGo_r;
		end
	end
endmodule : mvi_cpu_model
`default_nettype wire

// file: verif/multilevel_vectored_interrupt_priority_bench.sv
// bench for the interrupt controller with a cpu model
// assumes: 200 MHz mclk, async active-high reset
`default_nettype none
module multilevel_vectored_interrupt_priority_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, reset = 1, ackEn = 0, retGo = 0, haltMode = 0, holdMode = 0, cmpOut = 0;
	logic cmpOnPinC = 0, cmpFilterEn = 0, intAck, intReturn, intReq, haltRelease, holdWake;
	logic [5:0] pins = 0, pinLevelMode = 0, pinActiveHigh = 0;
	logic [15:0] per = 0, srcEnable = 16'hffff, srcFlagClear = 0, srcFlag;
	logic [9:0] vecHighSel = 0;
	logic [1:0] vecHighestSel = 0;
	logic [19:0] intVector;
	mvi_pkg::mvi_level_t intLevel, svcLevel;
	int err_total = 0, num_checks = 0;
	always #2.5 mclk = ~mclk;
	mvi_ctrl mvi_ctrl_inst (.mclk, .reset, .extIrqPinA(pins[0]), .extIrqPinB(pins[1]),
		.extIrqPinC(pins[2]), .extIrqPinD(pins[3]), .extIrqPinE(pins[4]), .extIrqPinF(pins[5]),
		.comparatorOutput(cmpOut), .pinLevelMode, .pinActiveHigh, .cmpOnPinC, .cmpFilterEn,
		.timer0LowHalfRequest(per[3]), .timer0HighHalfRequest(per[7]),
		.timer1LowHalfRequest(per[9]), .timer1HighHalfRequest(per[10]),
		.syncSerialRequest(per[8]), .pulseCounterOneRequest(per[11]),
		.pulseCounterTwoRequest(per[12]), .adcDoneRequest(per[13]),
		.fastPwmUnitStopRequest(per[14]), .fastPwmUnitCycleRequest(per[15]), .srcEnable,
		.srcFlagClear, .vecHighSel, .vecHighestSel, .intAck, .intReturn, .haltMode, .holdMode,
		.intReq, .intVector, .intLevel, .srcFlag, .svcLevel, .haltRelease, .holdWake);
	mvi_cpu_model mvi_cpu_model_inst (.mclk, .reset, .ackEn, .retGo, .intReq, .intAck,
		.intReturn);
	// ==========================================
	// helpers
	task automatic finish_test();
		if (err_total == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			err_total++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : chk
	task automatic wt(input int s);
		for (int i = 0; i < 40; i++) begin
			@(posedge mclk);
			#1;
			if ((s == 0 ? intReq : s == 1 ? haltRelease : holdWake) === 1'b1) return;
		end
		chk(1'b0, "wait ran out");
		finish_test();
	endtask : wt
	task automatic pulse(input logic [15:0] m);
		@(posedge mclk) per <= m;
		@(posedge mclk) per <= 16'h0000;
	endtask : pulse
	task automatic done();
		@(posedge mclk) ackEn <= 1'b1;
		repeat (3) @(posedge mclk);
		ackEn <= 1'b0;
		srcFlagClear <= 16'hffff;
		@(posedge mclk) srcFlagClear <= 16'h0000;
		retGo <= 1'b1;
		@(posedge mclk) retGo <= 1'b0;
		repeat (4) @(posedge mclk);
	endtask : done
	// ==========================================
	// scenarios
	task automatic s_walk();
		haltMode <= 1'b1;
		pulse(16'h0008);
		#1 chk(srcFlag[3] === 1'b1, "flag not set");
		wt(0);
		chk(intVector === 20'h00013 && intLevel === mvi_pkg::MVI_LVL_LOW, "walk vector");
		wt(1);
		haltMode <= 1'b0;
		done();
	endtask : s_walk
	task automatic s_order();
		pulse(16'h2008);
		wt(0);
		chk(intVector === 20'h00013, "tie order");
		done();
		vecHighSel <= 10'h100;
		pulse(16'h2008);
		wt(0);
		chk(intVector === 20'h00043 && intLevel === mvi_pkg::MVI_LVL_HIGH, "level order");
		done();
		vecHighSel <= 10'h000;
		for (int i = 13; i < 16; i++) begin
			pulse(16'h0001 << i);
			wt(0);
			chk(intVector === 20'h00043, "shared vector");
			done();
		end
	endtask : s_order
	task automatic s_nest();
		srcEnable[9] <= 1'b0;
		pulse(16'h0200);
		repeat (6) @(posedge mclk);
		chk(intReq === 1'b0 && srcFlag[9] === 1'b1, "disabled raised");
		srcFlagClear <= 16'h0200;
		@(posedge mclk) srcFlagClear <= 16'h0000;
		srcEnable[9] <= 1'b1;
		pulse(16'h0008);
		wt(0);
		@(posedge mclk) ackEn <= 1'b1;
		repeat (3) @(posedge mclk);
		ackEn <= 1'b0;
		pulse(16'h0200);
		repeat (6) @(posedge mclk);
		chk(svcLevel === mvi_pkg::MVI_LVL_LOW && intReq === 1'b0, "equal level nested");
		vecHighSel <= 10'h020;
		wt(0);
		chk(intVector === 20'h0002b && intLevel === mvi_pkg::MVI_LVL_HIGH, "nest");
		done();
		done();
		chk(svcLevel === mvi_pkg::MVI_LVL_NONE, "service level");
		vecHighSel <= 10'h000;
	endtask : s_nest
	task automatic s_pins();
		pinActiveHigh <= 6'h3d;
		vecHighestSel <= 2'h1;
		holdMode <= 1'b1;
		@(posedge mclk) pins <= 6'h01;
		repeat (5) @(posedge mclk);
		chk(holdWake === 1'b0, "edge pin woke hold");
		pinLevelMode <= 6'h01;
		wt(2);
		wt(0);
		chk(intVector === 20'h00003 && intLevel === mvi_pkg::MVI_LVL_HIGHEST, "top");
		pins <= 6'h00;
		holdMode <= 1'b0;
		done();
		cmpOnPinC <= 1'b1;
		cmpFilterEn <= 1'b1;
		@(posedge mclk) cmpOut <= 1'b1;
		repeat (5) @(posedge mclk);
		#1 chk(intReq === 1'b0, "filter not applied");
		wt(0);
		chk(srcFlag[2] === 1'b1 && intVector === 20'h00013, "comparator");
		done();
		@(posedge mclk) cmpOut <= 1'b0;
		repeat (8) @(posedge mclk);
		cmpFilterEn <= 1'b0;
		@(posedge mclk) cmpOut <= 1'b1;
		repeat (4) @(posedge mclk);
		#1 chk(intReq === 1'b1 && intVector === 20'h00013, "unfiltered path");
		done();
	endtask : s_pins
	task automatic s_reset();
		pulse(16'h0008);
		@(posedge mclk) reset <= 1'b1;
		repeat (2) @(posedge mclk);
		chk(srcFlag === 16'h0 && intReq === 1'b0 && intVector === 20'h00003, "reset");
		reset <= 1'b0;
		repeat (2) @(posedge mclk);
		chk(svcLevel === mvi_pkg::MVI_LVL_NONE && intReq === 1'b0, "after reset");
		repeat (10) @(posedge mclk);
		chk(srcFlag === 16'h0 && intReq === 1'b0, "false edge after reset");
	endtask : s_reset
	initial begin
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		repeat (2) @(posedge mclk);
		s_walk();
		s_order();
		s_nest();
		s_pins();
		s_reset();
		finish_test();
	end
endmodule : multilevel_vectored_interrupt_priority_bench
`default_nettype wire
